/* hw/ogsc_gain_clamp.sv */
// Overview of operation
// - compression bit set in configuration enables compressed input-to-code mapping.
// - expansion bit set in configuration enables expanded input-to-code mapping.
// - compression treats 10% to 90% of input range as full scale.
// - compression also applies to the common-mode output field.
// - expansion lets input exceed reference span by 0.78% before saturating.
// - expansion divides the differential output code by two.
// - expansion leaves the common-mode field unchanged.
// - with expansion, nominal full scale input gives plus or minus half the code space.
// - expansion clips at 407FFFFFh and BF800000h; 24-bit path takes upper bits.
// - without expansion saturate at most positive and most negative codes.
// - compression and expansion work together with the same saturation codes.
`timescale 1ns/1ps
`default_nettype none
module ogsc_gain_clamp (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // configuration word bits
  input wire logic gainCompressEnable,
  input wire logic gainExpandEnable,
  // raw core sample, same clock domain
  input wire logic sampleValid,
  input wire logic signed [ogsc_pkg::RAW_W-1:0] sampleDiff,
  input wire logic [ogsc_pkg::CM_W-1:0] sampleCm,
  // scaled output codes
  output logic [ogsc_pkg::FILT_W-1:0] filteredOutputCode,
  output logic [ogsc_pkg::NOLAT_W-1:0] noLatencyOutputCode,
  output logic [ogsc_pkg::CM_W-1:0] cmOutputCode,
  output logic codeValid
);

  ogsc_pkg::ogsc_state_t state_r;
  ogsc_pkg::ogsc_state_t state_nxt;

  logic signed [ogsc_pkg::WORK_W-1:0] diffWide;
  logic signed [ogsc_pkg::WORK_W-1:0] diffComp;
  logic signed [ogsc_pkg::WORK_W-1:0] diffScaled;
  logic signed [ogsc_pkg::WORK_W-1:0] limPos;
  logic signed [ogsc_pkg::WORK_W-1:0] limNeg;
  logic [ogsc_pkg::FILT_W-1:0] diffClamped;
  logic signed [9:0] cmWide;
  logic signed [9:0] cmComp;

  // sign-extend raw sample; +-2^31 stands for +-reference
  assign diffWide = {{(ogsc_pkg::WORK_W - ogsc_pkg::RAW_W){sampleDiff[ogsc_pkg::RAW_W-1]}}, sampleDiff};
  assign cmWide = {3'h0, sampleCm};

  // gain 1.25 maps +-0.8 reference onto full scale; no offset needed as span is symmetric
  always_comb begin
    if (gainCompressEnable) begin
      diffComp = diffWide + (diffWide >>> 2);
    end else begin
      diffComp = diffWide;
    end
  end

  // halve the scale and pick the matching clip points
  always_comb begin
    if (gainExpandEnable) begin
      diffScaled = diffComp >>> 1;
      limPos = ogsc_pkg::SAT_POS_EXP;
      limNeg = ogsc_pkg::SAT_NEG_EXP;
    end else begin
      diffScaled = diffComp;
      limPos = ogsc_pkg::SAT_POS_NOM;
      limNeg = ogsc_pkg::SAT_NEG_NOM;
    end
  end

  // saturation shared by both output paths so their codes always agree
  ogsc_clamp u_clamp (
    .value(diffScaled),
    .limPos(limPos),
    .limNeg(limNeg),
    .clamped(diffClamped)
  );

  // common mode: 1.25x minus 16 maps 10-90% onto 0..127; expansion ignored here
  always_comb begin
    if (gainCompressEnable) begin
      cmComp = cmWide + (cmWide >>> 2) - ogsc_pkg::CM_COMP_OFFSET;
    end else begin
      cmComp = cmWide;
    end
    if (cmComp > ogsc_pkg::CM_MAX) begin
      cmComp = ogsc_pkg::CM_MAX;
    end else if (cmComp < ogsc_pkg::CM_MIN) begin
      cmComp = ogsc_pkg::CM_MIN;
    end
  end

  // outputs hold the last code between samples, as a reader may fetch late
  always_comb begin
    state_nxt = state_r;
    state_nxt.codeValid = sampleValid;
    if (sampleValid) begin
      state_nxt.filtCode = diffClamped;
      state_nxt.noLatCode = diffClamped[ogsc_pkg::FILT_W-1:ogsc_pkg::FILT_W-ogsc_pkg::NOLAT_W];
      state_nxt.cmCode = cmComp[ogsc_pkg::CM_W-1:0];
    end
  end

  // single state register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= '{filtCode: ogsc_pkg::FILT_RST, noLatCode: ogsc_pkg::NOLAT_RST,
                   cmCode: ogsc_pkg::CM_RST, codeValid: 1'b0};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign filteredOutputCode = state_r.filtCode;
  assign noLatencyOutputCode = state_r.noLatCode;
  assign cmOutputCode = state_r.cmCode;
  assign codeValid = state_r.codeValid;

endmodule : ogsc_gain_clamp
`default_nettype wire

/* hw/ogsc_pkg.sv */
// shared constants and state type for the output gain scaling clamp
package ogsc_pkg;

  // configuration word bit positions for the two gain modes
  localparam int unsigned CFG_COMPRESS_BIT = 9;
  localparam int unsigned CFG_EXPAND_BIT = 8;

  // widths: raw core sample carries headroom beyond the reference
  localparam int unsigned RAW_W = 34;
  localparam int unsigned WORK_W = 36;
  localparam int unsigned FILT_W = 32;
  localparam int unsigned NOLAT_W = 24;
  localparam int unsigned CM_W = 7;

  // saturation limits on the 32-bit scale, sign-extended to the work width
  localparam logic signed [WORK_W-1:0] SAT_POS_NOM = 36'sh0_7FFF_FFFF;
  localparam logic signed [WORK_W-1:0] SAT_NEG_NOM = 36'shF_8000_0000;
  localparam logic signed [WORK_W-1:0] SAT_POS_EXP = 36'sh0_407F_FFFF;
  localparam logic signed [WORK_W-1:0] SAT_NEG_EXP = 36'shF_BF80_0000;

  // common-mode compression: 10% of 128 codes is 12.8, times 1.25 gives 16
  localparam logic signed [9:0] CM_COMP_OFFSET = 10'sh010;
  localparam logic signed [9:0] CM_MAX = 10'sh07F;
  localparam logic signed [9:0] CM_MIN = 10'sh000;

  // reset values of the output registers
  localparam logic [FILT_W-1:0] FILT_RST = 32'h0000_0000;
  localparam logic [NOLAT_W-1:0] NOLAT_RST = 24'h00_0000;
  localparam logic [CM_W-1:0] CM_RST = 7'h00;

  typedef struct packed {
    logic [FILT_W-1:0] filtCode;
    logic [NOLAT_W-1:0] noLatCode;
    logic [CM_W-1:0] cmCode;
    logic codeValid;
  } ogsc_state_t;

endpackage : ogsc_pkg

/* hw/ogsc_clamp.sv */
`timescale 1ns/1ps
`default_nettype none
// combinational saturation of a wide signed code to a 32-bit output word
module ogsc_clamp (
  // value and limits
  input wire logic signed [ogsc_pkg::WORK_W-1:0] value,
  input wire logic signed [ogsc_pkg::WORK_W-1:0] limPos,
  input wire logic signed [ogsc_pkg::WORK_W-1:0] limNeg,
  // clamped result
  output logic [ogsc_pkg::FILT_W-1:0] clamped
);

  // limits always fit in 32 bits, so the slice never loses sign information
  always_comb begin
    if (value > limPos) begin
      clamped = limPos[ogsc_pkg::FILT_W-1:0];
    end else if (value < limNeg) begin
      clamped = limNeg[ogsc_pkg::FILT_W-1:0];
    end else begin
      clamped = value[ogsc_pkg::FILT_W-1:0];
    end
  end

endmodule : ogsc_clamp
`default_nettype wire

/* sim/ogsc_gain_clamp_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module ogsc_gain_clamp_properties (
  // clock, reset, modes and sample
  input wire logic ref_clk, arst_n, gainCompressEnable, gainExpandEnable, sampleValid,
  input wire logic signed [33:0] sampleDiff,
  input wire logic [6:0] sampleCm, cmOutputCode,
  // results
  input wire logic [31:0] filteredOutputCode,
  input wire logic [23:0] noLatencyOutputCode,
  input wire logic codeValid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // timing of answers, then scaling limits
  a_answer_next: assert property (sampleValid |=> codeValid) else $error("late code");
  a_no_spurious: assert property (!sampleValid |=> !codeValid) else $error("extra code");
  a_codes_hold: assert property (!sampleValid |=> $stable(filteredOutputCode)) else $error("code moved");
  a_short_upper: assert property (noLatencyOutputCode == filteredOutputCode[31:8]) else $error("short code");
  a_cm_passes: assert property (sampleValid && !gainCompressEnable |=> cmOutputCode == $past(sampleCm))
    else $error("cm altered");
  a_nom_clip: assert property (sampleValid && !gainExpandEnable && sampleDiff >= 34'sh1_0000_0000
    |=> filteredOutputCode == 32'h7FFF_FFFF) else $error("nominal clip");
  a_exp_clip_hi: assert property (sampleValid && gainExpandEnable && sampleDiff >= 34'sh1_0000_0000
    |=> filteredOutputCode == 32'h407F_FFFF) else $error("expanded clip high");
  a_exp_clip_lo: assert property (sampleValid && gainExpandEnable && sampleDiff <= -34'sh1_0000_0000
    |=> filteredOutputCode == 32'hBF80_0000) else $error("expanded clip low");
  c_both_modes: cover property (sampleValid && gainCompressEnable && gainExpandEnable);
  c_back_to_back: cover property (sampleValid ##1 sampleValid);
  c_gap: cover property (!sampleValid ##1 sampleValid);
endmodule : ogsc_gain_clamp_properties
bind ogsc_gain_clamp ogsc_gain_clamp_properties u_chk (.ref_clk, .arst_n, .gainCompressEnable,
  .gainExpandEnable, .sampleValid, .sampleDiff, .sampleCm, .cmOutputCode, .filteredOutputCode,
  .noLatencyOutputCode, .codeValid);
`default_nettype wire

/* sim/ogsc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// host side: {valid, compress, expand, diff, cm}, applied just after the edge
module ogsc_host_model (
  input wire logic ref_clk,
  input wire logic [43:0] req,
  output logic [43:0] drv
);
  initial drv = '0;
  always @(posedge ref_clk) drv <= #1 req;
endmodule : ogsc_host_model
`default_nettype wire

/* sim/ogsc_gain_clamp_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module ogsc_gain_clamp_bench;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [43:0] req = '0;
  logic [43:0] drv;
  logic [31:0] filteredOutputCode, lfsr = 32'h0000_4637;
  logic [23:0] noLatencyOutputCode;
  logic [6:0] cmOutputCode;
  logic codeValid;
  logic [38:0] eq;
  logic [38:0] expQ[$];
  int miscompares = 0;
  int checks = 0;
  logic signed [33:0] corner[3] = '{34'sh0_8000_0000, -34'sh0_8000_0000, 34'sh0_6666_6666};
  ogsc_host_model u_host (.ref_clk(ref_clk), .req(req), .drv(drv));
  ogsc_gain_clamp u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .gainCompressEnable(drv[42]),
    .gainExpandEnable(drv[41]), .sampleValid(drv[43]), .sampleDiff(drv[40:7]), .sampleCm(drv[6:0]),
    .filteredOutputCode(filteredOutputCode), .noLatencyOutputCode(noLatencyOutputCode),
    .cmOutputCode(cmOutputCode), .codeValid(codeValid));
  function automatic logic [31:0] lfsr_next(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // reference scaling in 64 bits so nothing wraps before the clamp
  function automatic logic [31:0] m_diff(longint d, logic c, logic e);
    longint lim;
    lim = e ? 64'sh407F_FFFF : 64'sh7FFF_FFFF;
    d = c ? d + (d >>> 2) : d;
    d = e ? d >>> 1 : d;
    d = d > lim ? lim : (d < -lim - 1 ? -lim - 1 : d);
    return d[31:0];
  endfunction : m_diff
  function automatic logic [6:0] m_cm(int cm, logic c);
    cm = c ? cm + (cm >> 2) - 16 : cm;
    return cm < 0 ? 7'h00 : (cm > 127 ? 7'h7F : cm[6:0]);
  endfunction : m_cm
  task automatic cmp(string what, logic [31:0] e, logic [31:0] s);
    checks++;
    if (e !== s) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask : cmp
  // one cycle of traffic; idle cycles invert the stale sample
  task automatic send(logic [1:0] m, logic signed [33:0] d);
    // change the request off the edge so the host model never races it
    #2;
    lfsr = lfsr_next(lfsr);
    req = {lfsr[9] | lfsr[8], m, (lfsr[9] | lfsr[8]) ? d : ~req[40:7], lfsr[6:0]};
    if (req[43]) expQ.push_back({m_diff(d, m[1], m[0]), m_cm(lfsr[6:0], m[1])});
    @(posedge ref_clk);
  endtask : send
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  initial forever #20 ref_clk = ~ref_clk;
  // settled results checked mid-cycle
  always @(negedge ref_clk) begin
    if (codeValid !== 1'b0) begin
      eq = expQ.size() ? expQ.pop_front() : 39'h0;
      cmp("filtered", eq[38:7], filteredOutputCode);
      cmp("nolatency", {8'h00, eq[38:15]}, {8'h00, noLatencyOutputCode});
      cmp("commonmode", {25'h0, eq[6:0]}, {25'h0, cmOutputCode});
    end
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    @(posedge ref_clk);
    for (int m = 0; m < 4; m++) begin
      foreach (corner[i]) send(m[1:0], corner[i]);
      repeat (80) send(m[1:0], {lfsr[1:0], lfsr});
      $display("mode %0d done", m);
    end
    #2 req[43] = 1'b0;
    for (int i = 0; i < 4 && expQ.size() > 0; i++) @(posedge ref_clk);
    if (expQ.size() > 0) cmp("drain", 32'h0, 32'h1);
    tally_and_finish();
  end
endmodule : ogsc_gain_clamp_bench
`default_nettype wire
